// ### rtl/fcb_map.svh
// Purpose: named constants for the flash command bus host controller
// Assumes: 200 MHz reference clock, 5 ns period
// Notes:   register offsets are byte addresses on the wishbone port
`ifndef FCB_MAP_SVH
`define FCB_MAP_SVH

`define FCB_CLK_PS        32'd5000
`define FCB_SETUP_CYC     32'd2
`define FCB_WR_PULSE_NS   32'd40
`define FCB_WR_HIGH_NS    32'd30
`define FCB_RD_ACCESS_NS  32'd60
`define FCB_RST_LOW_NS    32'd500
`define FCB_RST_REC_NS    32'd50
`define FCB_RST_BUSY_US   32'd10

`define FCB_REG_CTRL      4'h0
`define FCB_REG_ADDR      4'h4
`define FCB_REG_DATA      4'h8
`define FCB_REG_STAT      4'hC

`define FCB_CTRL_GO       0
`define FCB_CTRL_OP_LO    1
`define FCB_CTRL_OP_HI    3
`define FCB_CTRL_WORD     4
`define FCB_CTRL_VID_RP   5
`define FCB_CTRL_VID_A9   6
`define FCB_CTRL_VID_OE   7

`define FCB_STAT_BUSY     0
`define FCB_STAT_RB       1
`define FCB_STAT_REJECT   2
`define FCB_STAT_POLL     15
`define FCB_STAT_TOGGLE   14
`define FCB_STAT_ERR      13
`define FCB_STAT_ETIM     11
`define FCB_STAT_TOG2     10

`define FCB_ULK1_ADDR     19'h05555
`define FCB_ULK2_ADDR     19'h02AAA
`define FCB_ULK1_DATA     8'hAA
`define FCB_ULK2_DATA     8'h55
`define FCB_CMD_READ      8'hF0
`define FCB_CMD_ASEL      8'h90
`define FCB_CMD_PROG      8'hA0
`define FCB_CMD_ERASE     8'h80
`define FCB_CMD_BERASE    8'h30
`define FCB_CMD_CERASE    8'h10
`define FCB_CMD_SUSP      8'hB0
`define FCB_CMD_RESUME    8'h30

`define FCB_SEQ_DEPTH     3'd6

`endif

// ### rtl/fcb_pkg.sv
// Purpose: types for the flash command bus host controller
// Assumes: included map header carries every number
// Notes:   operation codes are what software writes to ctrl
package fcb_pkg;
  typedef enum logic [2:0] {
    FCB_OP_READ, FCB_OP_ASEL, FCB_OP_PROG, FCB_OP_BERASE,
    FCB_OP_CERASE, FCB_OP_SUSP, FCB_OP_RESUME, FCB_OP_HWRST
  } fcb_op_t;
  typedef enum logic [2:0] {
    FCB_ST_IDLE, FCB_ST_SETUP, FCB_ST_STROBE, FCB_ST_GAP,
    FCB_ST_RDWAIT, FCB_ST_RSTLOW, FCB_ST_RSTREC
  } fcb_state_t;
endpackage

// ### rtl/fcb_seq_rom.sv
// Purpose: holds the address and data words of one command sequence
// Assumes: written by the controller before the sequence is played
// Notes:   read data is registered, one cycle latency
`timescale 1ns/1ps
module fcb_seq_rom #(
  parameter int DEPTH = 6,
  parameter int AW    = 19,
  parameter int DW    = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [2:0]               i_waddr,
  input  wire logic [AW+DW-1:0]         i_wdata,
  input  wire logic [2:0]               i_raddr,
  output logic      [AW+DW-1:0]         o_rdata
);
  logic [AW+DW-1:0] mem [DEPTH];        // sequence slots

  // write port, no reset needed on storage
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered read port
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // fcb_seq_rom

// ### rtl/fcb_host.sv
// Purpose: host controller driving a parallel boot-block flash
// Assumes: flash pins sampled synchronously to I_REF_CLK; wishbone slave
// Notes:   sequences are played as chip-enable/write-enable pulses
//
// Functional notes
// - program 4 writes, erase 6 writes
// - unlock on cycles 1,2 (erase also 4,5), none for suspend/resume; command after
// - program address and data on cycle four
// - erase unlocks twice, confirm on six
// - reset low 500ns, recovery 50ns or 10us
// - write: select low, write low, oe high
`timescale 1ns/1ps
`include "fcb_map.svh"
module fcb_host #(
  parameter int RST_BUSY_CYC = 2000     // 10 us at 200 MHz
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_CE,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [3:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  output logic      [17:0] O_FL_ADDR,
  input  wire logic [15:0] I_FL_DQ,
  output logic      [15:0] O_FL_DQ,
  output logic             O_FL_DQ_OE_N,
  output logic             O_FL_CHIP_SEL_N,
  output logic             O_FL_OUT_EN_N,
  output logic             O_FL_WR_EN_N,
  output logic             O_FL_WORD_MODE,
  output logic             O_FL_RESET_UNPROTECT_N,
  output logic             O_FL_HIGH_VOLTAGE_RP,
  output logic             O_FL_HIGH_VOLTAGE_A9,
  output logic             O_FL_HIGH_VOLTAGE_OE,
  input  wire logic        I_FL_READY_BUSY_N
);
  import fcb_pkg::*;

  // timing counts; least times round up
  localparam logic [15:0] WR_CYC = 16'((`FCB_WR_PULSE_NS*1000
                                      + `FCB_CLK_PS - 1) / `FCB_CLK_PS);
  localparam logic [15:0] HI_CYC = 16'((`FCB_WR_HIGH_NS*1000
                                      + `FCB_CLK_PS - 1) / `FCB_CLK_PS);
  localparam logic [15:0] RD_CYC = 16'((`FCB_RD_ACCESS_NS*1000
                                      + `FCB_CLK_PS - 1) / `FCB_CLK_PS);
  localparam logic [15:0] RL_CYC = 16'((`FCB_RST_LOW_NS*1000
                                      + `FCB_CLK_PS - 1) / `FCB_CLK_PS);
  localparam logic [15:0] RR_CYC = 16'((`FCB_RST_REC_NS*1000
                                      + `FCB_CLK_PS - 1) / `FCB_CLK_PS);
  localparam logic [15:0] RB_CYC = 16'(RST_BUSY_CYC);
  // one cycle for the registered slot read, one with address on the pins
  localparam logic [15:0] SU_CYC = 16'(`FCB_SETUP_CYC);

  fcb_state_t      state_q;             // pin sequencer state
  logic [2:0]      op_q;                // latched operation
  logic            word_q;              // word organisation select
  logic            vid_rp_q;            // high voltage on reset pin
  logic            vid_a9_q;            // high voltage on a9
  logic            vid_oe_q;            // high voltage on output enable
  logic [18:0]     addr_q;              // byte address (bit 0 = lsb)
  logic [15:0]     wdata_q;             // program data
  logic [15:0]     rdata_q;             // last sampled read data
  logic            reject_q;            // last request refused
  logic [2:0]      idx_q;               // current sequence slot
  logic [2:0]      len_q;               // one past the last slot played
  logic [15:0]     cnt_q;               // phase timer
  logic            rd_q;                // trailing read wanted
  logic            busy_pe_q;           // long recovery needed on reset
  logic            go;                  // start pulse from bus
  logic [2:0]      go_op;               // operation field of a go write
  logic            wb_req;              // bus access seen
  logic [34:0]     rom_wdata;           // slot word being loaded
  logic [2:0]      rom_waddr;           // slot being loaded
  logic            rom_we;              // loading strobe
  logic [34:0]     rom_rdata;           // slot being played
  logic [2:0]      load_q;              // load pointer
  logic            loading_q;           // loading in progress

  // unlock slot word builder, unlock values played by all ops but suspend, resume and hardware reset
  function automatic logic [34:0] slot(input logic [18:0] a,
                                       input logic [7:0]  d);
    slot = {a, 8'h00, d};
  endfunction

  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign go = wb_req && I_WB_WE && I_WB_ADR == `FCB_REG_CTRL
              && I_WB_SEL[0] && I_WB_DAT[`FCB_CTRL_GO];
  assign go_op = I_WB_DAT[`FCB_CTRL_OP_HI:`FCB_CTRL_OP_LO];

  // wishbone ack, one cycle after request, dropped next cycle
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WB_ACK <= 1'b0;
    end else if (I_CE) begin
      O_WB_ACK <= wb_req;
    end
  end

  // register reads; unmapped offsets read zero
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WB_DAT <= 32'h0000_0000;
    end else if (I_CE && wb_req && !I_WB_WE) begin
      case (I_WB_ADR)
        `FCB_REG_CTRL: O_WB_DAT <= {24'h0, vid_oe_q, vid_a9_q, vid_rp_q,
                                    word_q, op_q, 1'b0};
        `FCB_REG_ADDR: O_WB_DAT <= {13'h0, addr_q};
        `FCB_REG_DATA: O_WB_DAT <= {16'h0, rdata_q};
        `FCB_REG_STAT: O_WB_DAT <= {rdata_q, 13'h0, reject_q,
                                    I_FL_READY_BUSY_N,
                                    // slot loading counts as busy
                                    (state_q != FCB_ST_IDLE || loading_q)};
        default:       O_WB_DAT <= 32'h0000_0000;
      endcase
    end
  end

  // config writes; ignored while a sequence runs
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      op_q     <= 3'h0;
      word_q   <= 1'b1;
      vid_rp_q <= 1'b0;
      vid_a9_q <= 1'b0;
      vid_oe_q <= 1'b0;
      addr_q   <= 19'h0;
      wdata_q  <= 16'h0;
    end else if (I_CE && wb_req && I_WB_WE && state_q == FCB_ST_IDLE
                 && !loading_q) begin
      case (I_WB_ADR)
        `FCB_REG_CTRL: if (I_WB_SEL[0]) begin
          op_q     <= I_WB_DAT[`FCB_CTRL_OP_HI:`FCB_CTRL_OP_LO];
          word_q   <= I_WB_DAT[`FCB_CTRL_WORD];
          vid_rp_q <= I_WB_DAT[`FCB_CTRL_VID_RP];
          vid_a9_q <= I_WB_DAT[`FCB_CTRL_VID_A9];
          vid_oe_q <= I_WB_DAT[`FCB_CTRL_VID_OE];
        end
        `FCB_REG_ADDR: addr_q <= I_WB_DAT[18:0];
        `FCB_REG_DATA: wdata_q <= I_WB_DAT[15:0];
        default: ;
      endcase
    end
  end

  // sequence builder: fills slots for the chosen op
  always_comb begin
    rom_waddr = load_q;
    rom_we    = loading_q;
    case (load_q)
      3'd0: rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_ULK1_DATA);
      3'd1: rom_wdata = slot(`FCB_ULK2_ADDR, `FCB_ULK2_DATA);
      3'd2: begin
        case (fcb_op_t'(op_q))
          FCB_OP_READ:   rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_CMD_READ);
          FCB_OP_ASEL:   rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_CMD_ASEL);
          FCB_OP_PROG:   rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_CMD_PROG);
          FCB_OP_SUSP:   rom_wdata = slot(addr_q, `FCB_CMD_SUSP);
          FCB_OP_RESUME: rom_wdata = slot(addr_q, `FCB_CMD_RESUME);
          default:       rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_CMD_ERASE);
        endcase
      end
      3'd3: begin
        if (fcb_op_t'(op_q) == FCB_OP_PROG) begin
          rom_wdata = {addr_q, wdata_q};
        end else begin
          rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_ULK1_DATA);
        end
      end
      3'd4: rom_wdata = slot(`FCB_ULK2_ADDR, `FCB_ULK2_DATA);
      default: begin
        if (fcb_op_t'(op_q) == FCB_OP_CERASE) begin
          rom_wdata = slot(`FCB_ULK1_ADDR, `FCB_CMD_CERASE);
        end else begin
          rom_wdata = slot(addr_q, `FCB_CMD_BERASE);
        end
      end
    endcase
  end

  // load pointer: runs through every slot before play
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      loading_q <= 1'b0;
      load_q    <= 3'd0;
    end else if (I_CE) begin
      if (go && state_q == FCB_ST_IDLE && !loading_q) begin
        loading_q <= 1'b1;
        load_q    <= 3'd0;
      end else if (loading_q) begin
        load_q <= load_q + 3'd1;
        if (load_q == `FCB_SEQ_DEPTH - 3'd1) begin
          loading_q <= 1'b0;
        end
      end
    end
  end

  fcb_seq_rom #(.DEPTH(6), .AW(19), .DW(16)) u_rom (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_ce     (I_CE),
    .i_we     (rom_we),
    .i_waddr  (rom_waddr),
    .i_wdata  (rom_wdata),
    .i_raddr  (idx_q),
    .o_rdata  (rom_rdata)
  );

  // pin sequencer
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      // power-up starts with a full reset pulse on the flash pin
      state_q   <= FCB_ST_RSTLOW;
      idx_q     <= 3'd0;
      len_q     <= 3'd0;
      cnt_q     <= 16'h0;
      rd_q      <= 1'b0;
      reject_q  <= 1'b0;
      busy_pe_q <= 1'b0;
      rdata_q   <= 16'h0;
    end else if (I_CE) begin
      case (state_q)
        FCB_ST_IDLE: begin
          if (go) begin
            // busy device refuses program and erase; reads show status
            reject_q <= !I_FL_READY_BUSY_N
                        && (fcb_op_t'(go_op) inside {FCB_OP_PROG,
                            FCB_OP_BERASE, FCB_OP_CERASE});
          end else if (loading_q && load_q == `FCB_SEQ_DEPTH - 3'd1
                       && !reject_q) begin
            idx_q <= 3'd0;
            cnt_q <= 16'h0;
            rd_q  <= fcb_op_t'(op_q) == FCB_OP_READ
                     || fcb_op_t'(op_q) == FCB_OP_ASEL;
            case (fcb_op_t'(op_q))
              FCB_OP_PROG:   len_q <= 3'd4;
              FCB_OP_BERASE,
              FCB_OP_CERASE: len_q <= 3'd6;
              default:       len_q <= 3'd3;
            endcase
            if (fcb_op_t'(op_q) == FCB_OP_HWRST) begin
              busy_pe_q <= !I_FL_READY_BUSY_N;
              state_q   <= FCB_ST_RSTLOW;
            end else if (fcb_op_t'(op_q) == FCB_OP_SUSP
                         || fcb_op_t'(op_q) == FCB_OP_RESUME) begin
              idx_q   <= 3'd2;
              len_q   <= 3'd3;
              state_q <= FCB_ST_SETUP;
            end else begin
              state_q <= FCB_ST_SETUP;
            end
          end
        end
        FCB_ST_SETUP: begin
          // rom read settles, address goes out before strobe
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= SU_CYC) begin
            state_q <= FCB_ST_STROBE;
            cnt_q   <= 16'h0;
          end
        end
        FCB_ST_STROBE: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= WR_CYC) begin
            state_q <= FCB_ST_GAP;
            cnt_q   <= 16'h0;
          end
        end
        FCB_ST_GAP: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= HI_CYC) begin
            cnt_q <= 16'h0;
            if (idx_q + 3'd1 < len_q) begin
              idx_q   <= idx_q + 3'd1;
              state_q <= FCB_ST_SETUP;
            end else if (rd_q) begin
              state_q <= FCB_ST_RDWAIT;
            end else begin
              state_q <= FCB_ST_IDLE;
            end
          end
        end
        FCB_ST_RDWAIT: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= RD_CYC) begin
            rdata_q <= word_q ? I_FL_DQ : {8'h00, I_FL_DQ[7:0]};
            state_q <= FCB_ST_IDLE;
          end
        end
        FCB_ST_RSTLOW: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= RL_CYC) begin
            cnt_q   <= 16'h0;
            state_q <= FCB_ST_RSTREC;
          end
        end
        FCB_ST_RSTREC: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q + 16'h1 >= (busy_pe_q ? RB_CYC : RR_CYC)
              && I_FL_READY_BUSY_N) begin
            state_q <= FCB_ST_IDLE;
          end
        end
        default: state_q <= FCB_ST_IDLE;
      endcase
    end
  end

  // flash pins, all registered
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_FL_ADDR              <= 18'h0;
      O_FL_DQ                <= 16'h0;
      O_FL_DQ_OE_N           <= 1'b1;
      O_FL_CHIP_SEL_N        <= 1'b1;
      O_FL_OUT_EN_N          <= 1'b1;
      O_FL_WR_EN_N           <= 1'b1;
      O_FL_WORD_MODE         <= 1'b1;
      O_FL_RESET_UNPROTECT_N <= 1'b0;  // held low: device starts in read
      O_FL_HIGH_VOLTAGE_RP   <= 1'b0;
      O_FL_HIGH_VOLTAGE_A9   <= 1'b0;
      O_FL_HIGH_VOLTAGE_OE   <= 1'b0;
    end else if (I_CE) begin
      O_FL_WORD_MODE         <= word_q;
      O_FL_HIGH_VOLTAGE_RP   <= vid_rp_q;
      O_FL_HIGH_VOLTAGE_A9   <= vid_a9_q;
      O_FL_HIGH_VOLTAGE_OE   <= vid_oe_q;
      O_FL_RESET_UNPROTECT_N <= state_q != FCB_ST_RSTLOW;
      case (state_q)
        FCB_ST_SETUP, FCB_ST_STROBE, FCB_ST_GAP: begin
          // word mode drops the lsb; byte mode puts it on dq15
          O_FL_ADDR       <= word_q ? rom_rdata[34:17] : rom_rdata[35-1:17];
          O_FL_DQ         <= word_q ? rom_rdata[15:0]
                             : {rom_rdata[16], 7'h00, rom_rdata[7:0]};
          O_FL_DQ_OE_N    <= 1'b0;
          O_FL_OUT_EN_N   <= 1'b1;
          // select held low for the whole cycle, write enable strobes
          O_FL_CHIP_SEL_N <= 1'b0;
          O_FL_WR_EN_N    <= state_q != FCB_ST_STROBE;
        end
        FCB_ST_RDWAIT: begin
          O_FL_ADDR       <= addr_q[18:1];
          O_FL_DQ         <= {addr_q[0], 15'h0};
          O_FL_DQ_OE_N    <= word_q;   // byte mode still drives lsb line
          O_FL_CHIP_SEL_N <= 1'b0;
          O_FL_OUT_EN_N   <= 1'b0;
          O_FL_WR_EN_N    <= 1'b1;
        end
        default: begin
          O_FL_DQ_OE_N    <= 1'b1;
          O_FL_CHIP_SEL_N <= 1'b1;
          O_FL_OUT_EN_N   <= 1'b1;
          O_FL_WR_EN_N    <= 1'b1;
        end
      endcase
    end
  end

  // never read and write the flash at once
  property p_no_bus_fight;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      !O_FL_WR_EN_N |-> O_FL_OUT_EN_N && !O_FL_DQ_OE_N;
  endproperty
  a_no_bus_fight: assert property (p_no_bus_fight)
    else $error("write strobe with output enable active");

  property p_ack_drops;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      I_CE && O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_drops: assert property (p_ack_drops)
    else $error("ack held over two cycles");

  property p_reset_pulse;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      $fell(O_FL_RESET_UNPROTECT_N) && I_CE |-> !O_FL_RESET_UNPROTECT_N [*8];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset pulse too short");

  property p_oe_reads_only;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      !O_FL_OUT_EN_N |-> !O_FL_CHIP_SEL_N && O_FL_WR_EN_N;
  endproperty
  a_oe_reads_only: assert property (p_oe_reads_only)
    else $error("output enable without chip select");

  // address settles a cycle before the write strobe falls
  property p_addr_before_strobe;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      $fell(O_FL_WR_EN_N) |-> $stable(O_FL_ADDR) && !O_FL_CHIP_SEL_N;
  endproperty
  a_addr_before_strobe: assert property (p_addr_before_strobe)
    else $error("address moved with the write strobe");

  // data still driven when the write strobe rises
  property p_data_at_rise;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      $rose(O_FL_WR_EN_N) |-> $stable(O_FL_DQ) && !O_FL_DQ_OE_N;
  endproperty
  a_data_at_rise: assert property (p_data_at_rise)
    else $error("data moved with the write strobe");
endmodule // fcb_host

// ### tb/fcb_flash_model.sv
// Purpose: behavioural boot-block flash for the host bench
// Assumes: word mode, writes strobed by write enable
// Notes:   busy time counts 5 ns steps; cells never written read erased
`timescale 1ns/1ps
`include "fcb_map.svh"
module fcb_flash_model #(
  parameter int         PROG_T  = 40,
  parameter int         ERASE_T = 400,
  parameter int         RST_T   = 60,
  parameter logic [7:0] MFR_ID  = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'hA5   // arbitrary value
) (
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic             o_drv,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rst_n,
  output logic             o_rb_n
);
  logic [15:0] mem [int];          // array contents
  logic [17:0] a_q;                // address latched on strobe fall
  logic [7:0]  pd;                 // last programmed low byte
  int          cnt;                // decoder step; erase path jumps to 6 after its third write
  int          left;               // busy steps still to run
  logic        asel, ers, susp, tog, short_rst;
  realtime     t_low;              // time reset pin fell
  initial begin
    {cnt, left, asel, ers, susp, tog, short_rst, pd} = '0;
  end
  // busy only while the controller runs and is not suspended
  assign o_rb_n = !(left > 0 && !susp);
  assign o_drv  = !i_cs_n && !i_oe_n && i_rst_n;
  // status while busy, codes in auto select, else array data
  always_comb begin
    if (!o_rb_n)
      o_dq = {8'h00, ~pd[7], tog, 2'b00, ers, tog, 2'b00};
    else if (asel)
      o_dq = {8'h00, i_addr[0] ? DEV_ID : MFR_ID};
    else
      o_dq = mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
  end
  // the controller times itself, no host cycles needed
  always #5 if (left > 0 && !susp) begin
    left = left - 1;
    if (left == 0) ers = 1'b0;
  end
  always @(negedge i_oe_n) tog = ~tog;
  always @(negedge i_we_n) if (!i_cs_n) a_q = i_addr;
  always @(posedge i_we_n) if (!i_cs_n && i_rst_n) step(i_dq[7:0]);
  // command decoder: any wrong byte drops back to the first unlock cycle
  task automatic step(input logic [7:0] d);
    if (!o_rb_n) begin
      if (d == `FCB_CMD_SUSP && ers) susp = 1'b1;
      cnt = 0;
    end else if (susp && cnt == 0 && d == `FCB_CMD_RESUME) begin
      susp = 1'b0;
    end else case (cnt)
      0: cnt = (d == `FCB_ULK1_DATA) ? 1 : 0;
      1: cnt = (d == `FCB_ULK2_DATA) ? 2 : 0;
      2: begin
        asel = (d == `FCB_CMD_ASEL);
        cnt  = (d == `FCB_CMD_PROG) ? 3 : (d == `FCB_CMD_ERASE) ? 6 : 0;
      end
      3: begin
        mem[a_q] = i_dq;
        pd       = d;
        left     = PROG_T;
        cnt      = 0;
      end
      6: cnt = (d == `FCB_ULK1_DATA) ? 7 : 0;
      7: cnt = (d == `FCB_ULK2_DATA) ? 8 : 0;
      default: begin
        if (d == `FCB_CMD_BERASE || d == `FCB_CMD_CERASE) begin
          mem.delete();
          ers  = 1'b1;
          pd   = 8'hFF;
          left = ERASE_T;
        end
        cnt = 0;
      end
    endcase
  endtask
  always @(negedge i_rst_n) begin
    t_low = $realtime;
    cnt   = 0;
    asel  = 1'b0;
  end
  // a reset from busy aborts and keeps ready low a while
  always @(posedge i_rst_n) begin
    if ($realtime - t_low < 500.0) short_rst = 1'b1;
    if (left > 0 || susp) begin
      left = RST_T;
      susp = 1'b0;
      ers  = 1'b0;
    end
  end
endmodule // fcb_flash_model

// ### tb/flash_command_bus_interface_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the pins, wishbone master tasks
// Notes:   word mode only; ids of the model are arbitrary
`timescale 1ns/1ps
module flash_command_bus_interface_tb;
  logic clk, rst_n, cyc, stb, wen, ack, cs_n, oe_n, we_n, rp_n;
  logic dq_oe_n, drv, rb_n;
  logic [3:0]  adr;
  logic [3:0]  hv;
  logic [31:0] wdat, rdat, q;
  logic [17:0] fa;
  logic [15:0] dq_o, fq, dq_w, dq_last;
  int err_total, cmp_count;
  // released bus shows a changing pattern, not the last value
  assign dq_w = !dq_oe_n ? dq_o : drv ? fq : ~dq_last;
  always @(posedge clk) dq_last <= dq_w;
  fcb_host #(.RST_BUSY_CYC(20)) i_dut (
    .I_REF_CLK(clk), .I_ARST_N(rst_n), .I_CE(1'b1), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(wen), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_FL_ADDR(fa),
    .I_FL_DQ(dq_w), .O_FL_DQ(dq_o), .O_FL_DQ_OE_N(dq_oe_n),
    .O_FL_CHIP_SEL_N(cs_n), .O_FL_OUT_EN_N(oe_n), .O_FL_WR_EN_N(we_n),
    .O_FL_WORD_MODE(hv[3]), .O_FL_RESET_UNPROTECT_N(rp_n),
    .O_FL_HIGH_VOLTAGE_RP(hv[0]), .O_FL_HIGH_VOLTAGE_A9(hv[1]),
    .O_FL_HIGH_VOLTAGE_OE(hv[2]), .I_FL_READY_BUSY_N(rb_n));
  // long program time so a status read fits inside it
  fcb_flash_model #(.PROG_T(300)) i_flash (.i_addr(fa), .i_dq(dq_w),
    .o_dq(fq), .o_drv(drv), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_rst_n(rp_n), .o_rb_n(rb_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, wen, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      err_total++;
      test_done;
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // poll one status bit until it reads the wanted level
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, 4'hC, 32'h0);
      n++;
    end while (q[b] !== v && n < 3000);
    if (q[b] !== v) begin
      err_total++;
      test_done;
    end
  endtask
  task automatic go(input logic [31:0] c);
    wb(1'b1, 4'h0, c);
    wait_st(0, 1'b0);
  endtask
  task automatic t_reset;
    chk({rp_n, cs_n, we_n, dq_oe_n, ack}, 32'hE);
    wb(1'b0, 4'hC, 32'h0);
    chk(q & 32'h7, 32'h3);
    wait_st(0, 1'b0);
    chk(q & 32'h7, 32'h2);
    wb(1'b1, 4'h0, 32'hF0);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'hF0);
    chk(hv, 32'hF);
    wb(1'b1, 4'h0, 32'h10);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_prog;
    wb(1'b1, 4'h4, 32'h246);
    wb(1'b1, 4'h8, 32'hC35A);
    go(32'h15);
    // a read during the program returns the status word
    go(32'h11);
    wb(1'b0, 4'hC, 32'h0);
    chk({q[23], q[21], q[19], q[1]}, 32'h8);
    wait_st(1, 1'b1);
    chk(i_flash.mem[18'h123], 32'hC35A);
    go(32'h11);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[15:0], 32'hC35A);
    $display("program test done");
  endtask
  task automatic t_reject;
    wb(1'b1, 4'h4, 32'h400);
    go(32'h15);
    go(32'h15);
    chk(q[2], 1'b1);
    wait_st(1, 1'b1);
    $display("reject test done");
  endtask
  task automatic t_erase;
    wb(1'b1, 4'h4, 32'h246);
    go(32'h17);
    go(32'h1B);
    chk(q[1], 1'b1);
    go(32'h1D);
    chk(q[1], 1'b0);
    wait_st(1, 1'b1);
    go(32'h11);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[15:0], 32'hFFFF);
    $display("erase test done");
  endtask
  task automatic t_ident;
    wb(1'b1, 4'h4, 32'h0);
    go(32'h13);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[15:0], {8'h00, i_flash.MFR_ID});
    go(32'h1F);
    wait_st(1, 1'b1);
    chk(i_flash.short_rst, 1'b0);
    $display("ident and reset test done");
  endtask
  initial begin
    {err_total, cmp_count} = '0;
    {rst_n, cyc, stb, wen, adr, wdat} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_prog;
    t_reject;
    t_erase;
    t_ident;
    test_done;
  end
endmodule // flash_command_bus_interface_tb
